// file: rtl/dsadc_map.svh
// register offsets, fields, reset values and timing constants of the converter sequencer
`ifndef DSADC_MAP_SVH
`define DSADC_MAP_SVH

`define DSADC_ADDR_W        4
`define DSADC_OFF_CTRL      4'h0
`define DSADC_OFF_CFG       4'h1
`define DSADC_OFF_STAT      4'h2
`define DSADC_OFF_RESULT    4'h3
`define DSADC_OFF_IRQ_STAT  4'h4
`define DSADC_OFF_IRQ_MASK  4'h5

`define DSADC_CTRL_START    0
`define DSADC_CTRL_STOP     1
`define DSADC_CFG_MODE_LO   0
`define DSADC_CFG_MODE_HI   1
`define DSADC_CFG_RES8      2
`define DSADC_CFG_DEC_LO    8
`define DSADC_CFG_DEC_HI    15
`define DSADC_STAT_DONE     0
`define DSADC_STAT_BUSY     1
`define DSADC_STAT_VALID    2
`define DSADC_IRQ_DONE      0
`define DSADC_IRQ_OVR       1

`define DSADC_CFG_RST       16'h4000
`define DSADC_PRIME_N       3'h4
`define DSADC_SINC_ORDER    4
`endif

// file: rtl/dsadc_pkg.sv
// types shared by the converter sequencer
package dsadc_pkg;
    typedef enum logic [1:0] {
        DSADC_MODE_SINGLE,
        DSADC_MODE_MULTI,
        DSADC_MODE_CONT,
        DSADC_MODE_TURBO
    } dsadc_mode_t;

    typedef enum logic [1:0] {
        DSADC_ST_IDLE,
        DSADC_ST_PRIME,
        DSADC_ST_RUN,
        DSADC_ST_HOLD
    } dsadc_state_t;
endpackage

// file: rtl/dsadc_seq.sv
// delta-sigma converter sequencer: sinc4 decimator, mode control, registers
`include "dsadc_map.svh"
module dsadc_seq
    import dsadc_pkg::*;
#(
    parameter int ACC_W = 34,
    parameter int RES_W = 16
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    input  wire logic [`DSADC_ADDR_W-1:0] i_addr,
    input  wire logic [15:0]              i_wdata,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    output logic      [15:0]              o_rdata,
    input  wire logic                     i_mod_bit,
    input  wire logic                     i_soc,
    input  wire logic                     i_mux_change,
    input  wire logic                     i_dma_ack,
    output logic                          o_mod_rst,
    output logic                          o_eoc,
    output logic                          o_irq
);
    // pins from outside pass two flops
    logic [1:0] bit_sync_ff;
    logic [1:0] soc_sync_ff;
    logic [1:0] mux_sync_ff;
    logic       soc_prev_ff;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bit_sync_ff <= 2'h0;
            soc_sync_ff <= 2'h0;
            mux_sync_ff <= 2'h0;
            soc_prev_ff <= 1'b0;
        end else begin
            bit_sync_ff <= {bit_sync_ff[0], i_mod_bit};
            soc_sync_ff <= {soc_sync_ff[0], i_soc};
            mux_sync_ff <= {mux_sync_ff[0], i_mux_change};
            soc_prev_ff <= soc_sync_ff[1];
        end
    end
    logic mbit;
    logic soc_rise;
    logic mux_rise;
    assign mbit     = bit_sync_ff[1];
    assign soc_rise = soc_sync_ff[1] & ~soc_prev_ff;
    assign mux_rise = mux_sync_ff[1];

    // configuration
    logic [15:0]  cfg_ff;
    logic [1:0]   irq_mask_ff;
    dsadc_mode_t  mode;
    logic [7:0]   dec_ratio;
    logic         res8;
    assign mode      = dsadc_mode_t'(cfg_ff[`DSADC_CFG_MODE_HI:`DSADC_CFG_MODE_LO]);
    assign dec_ratio = cfg_ff[`DSADC_CFG_DEC_HI:`DSADC_CFG_DEC_LO];
    assign res8      = cfg_ff[`DSADC_CFG_RES8];

    logic wr_ctrl;
    logic start_req;
    logic stop_req;
    logic rd_result;
    assign wr_ctrl   = i_wr && (i_addr == `DSADC_OFF_CTRL);
    assign start_req = (wr_ctrl && i_wdata[`DSADC_CTRL_START]) || soc_rise;
    assign stop_req  = wr_ctrl && i_wdata[`DSADC_CTRL_STOP];
    assign rd_result = (i_rd && (i_addr == `DSADC_OFF_RESULT)) || i_dma_ack;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg_ff      <= `DSADC_CFG_RST;
            irq_mask_ff <= 2'h0;
        end else if (i_wr) begin
            if (i_addr == `DSADC_OFF_CFG) begin
                cfg_ff <= i_wdata;
            end
            if (i_addr == `DSADC_OFF_IRQ_MASK) begin
                irq_mask_ff <= i_wdata[1:0];
            end
        end
    end

    // sinc4 decimator: four integrators at clock rate, four combs at output rate
    // separate input array keeps each register element under a single process
    logic [ACC_W-1:0] integ_ff  [1:`DSADC_SINC_ORDER];
    logic [ACC_W-1:0] integ_src [1:`DSADC_SINC_ORDER];
    logic [ACC_W-1:0] comb_ff   [1:`DSADC_SINC_ORDER];
    logic [ACC_W-1:0] comb_in   [0:`DSADC_SINC_ORDER];
    logic [7:0]       dec_cnt_ff;
    logic             dec_tick;
    logic             dec_clr;
    assign dec_tick    = (dec_cnt_ff == 8'h00);
    genvar g;
    generate
        for (g = 1; g <= `DSADC_SINC_ORDER; g++) begin : g_sinc
            if (g == 1) begin : g_first
                assign integ_src[g] = {{(ACC_W-1){1'b0}}, mbit};
            end else begin : g_next
                assign integ_src[g] = integ_ff[g-1];
            end
            always_ff @(posedge i_clk) begin
                if (i_rst || dec_clr) begin
                    integ_ff[g] <= '0;
                    comb_ff[g]  <= '0;
                end else begin
                    integ_ff[g] <= integ_ff[g] + integ_src[g];
                    if (dec_tick) begin
                        comb_ff[g] <= comb_in[g-1];
                    end
                end
            end
            assign comb_in[g] = comb_in[g-1] - comb_ff[g];
        end
    endgenerate
    assign comb_in[0] = integ_ff[`DSADC_SINC_ORDER];

    // divider sets the output sample rate
    always_ff @(posedge i_clk) begin
        if (i_rst || dec_clr || dec_tick) begin
            dec_cnt_ff <= dec_ratio;
        end else begin
            dec_cnt_ff <= dec_cnt_ff - 8'h01;
        end
    end

    // sequencer
    dsadc_state_t state_ff;
    logic [2:0]   prime_ff;
    logic [15:0]  result_ff;
    logic         done_ff;
    logic         ovr_ff;
    logic         result_rdy;
    logic [15:0]  word;
    // width traded against rate: 8-bit keeps the top byte
    assign word = res8 ? {8'h00, comb_in[`DSADC_SINC_ORDER][ACC_W-1 -: 8]}
                       : {4'h0, comb_in[`DSADC_SINC_ORDER][ACC_W-1 -: 12]};
    // the fourth sample after a restart or mux change is the first valid one
    assign result_rdy = (state_ff != DSADC_ST_IDLE) && (state_ff != DSADC_ST_HOLD)
                        && dec_tick && (prime_ff == `DSADC_PRIME_N - 3'h1) && !mux_rise;
    // modulator and decimator held in reset outside a conversion
    assign dec_clr   = (state_ff == DSADC_ST_IDLE) || (state_ff == DSADC_ST_HOLD);
    assign o_mod_rst = dec_clr;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff <= DSADC_ST_IDLE;
            prime_ff <= 3'h0;
        end else if (stop_req) begin
            state_ff <= DSADC_ST_IDLE;
            prime_ff <= 3'h0;
        end else begin
            unique case (state_ff)
                DSADC_ST_IDLE: begin
                    prime_ff <= 3'h0;
                    if (start_req) begin
                        state_ff <= DSADC_ST_PRIME;
                    end
                end
                DSADC_ST_PRIME: begin
                    if (mux_rise) begin
                        prime_ff <= 3'h0;
                    end else if (result_rdy) begin
                        unique case (mode)
                            DSADC_MODE_SINGLE: state_ff <= DSADC_ST_HOLD;
                            DSADC_MODE_CONT:   state_ff <= DSADC_ST_RUN;
                            DSADC_MODE_MULTI,
                            DSADC_MODE_TURBO:  state_ff <= DSADC_ST_HOLD;
                        endcase
                    end else if (dec_tick) begin
                        prime_ff <= prime_ff + 3'h1;
                    end
                end
                DSADC_ST_RUN: begin
                    if (mux_rise) begin
                        state_ff <= DSADC_ST_PRIME;
                        prime_ff <= 3'h0;
                    end
                end
                DSADC_ST_HOLD: begin
                    prime_ff <= 3'h0;
                    // multi restarts at once: one cycle of reset then re-prime
                    if (mode == DSADC_MODE_MULTI || mode == DSADC_MODE_TURBO) begin
                        state_ff <= DSADC_ST_PRIME;
                    end else if (rd_result || !done_ff) begin
                        state_ff <= DSADC_ST_IDLE;
                    end
                end
            endcase
        end
    end

    logic new_res;
    // a word taken while the mux moves mixes two inputs, so it is dropped
    assign new_res = result_rdy || ((state_ff == DSADC_ST_RUN) && dec_tick && !mux_rise);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            result_ff <= 16'h0000;
        end else if (new_res) begin
            result_ff <= word;
        end
    end

    // done is set on each result and cleared by a read; a set wins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            done_ff <= 1'b0;
            ovr_ff  <= 1'b0;
        end else begin
            if (new_res) begin
                done_ff <= 1'b1;
            end else if (rd_result) begin
                done_ff <= 1'b0;
            end
            ovr_ff <= new_res && done_ff && !rd_result;
        end
    end
    assign o_eoc = done_ff;

    // sticky interrupt status, write one to clear
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_set;
    assign irq_set = {ovr_ff, new_res};
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_stat_ff <= 2'h0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (irq_set[b]) begin
                    irq_stat_ff[b] <= 1'b1;
                end else if (i_wr && (i_addr == `DSADC_OFF_IRQ_STAT) && i_wdata[b]) begin
                    irq_stat_ff[b] <= 1'b0;
                end
            end
        end
    end
    assign o_irq = |(irq_stat_ff & irq_mask_ff);

    // read port: data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_rd) begin
            o_rdata <= 16'h0000;
        end else begin
            unique case (i_addr)
                `DSADC_OFF_CFG:      o_rdata <= cfg_ff;
                `DSADC_OFF_STAT:     o_rdata <= {13'h0000, (state_ff == DSADC_ST_RUN),
                                                 !dec_clr, done_ff};
                `DSADC_OFF_RESULT:   o_rdata <= result_ff;
                `DSADC_OFF_IRQ_STAT: o_rdata <= {14'h0000, irq_stat_ff};
                `DSADC_OFF_IRQ_MASK: o_rdata <= {14'h0000, irq_mask_ff};
                default:             o_rdata <= 16'h0000;
            endcase
        end
    end
endmodule

// file: test/dsadc_seq_props.sv
// port checker for the converter sequencer
`include "dsadc_map.svh"
module dsadc_seq_props (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [3:0]  i_addr,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        i_mux_change,
    input wire logic        i_dma_ack,
    input wire logic        o_mod_rst,
    input wire logic        o_eoc,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // mux held long enough to have crossed the synchroniser
    sequence s_mux_hold;
        i_mux_change [*4];
    endsequence
    sequence s_stat_read;
        i_rd && i_addr == `DSADC_OFF_STAT;
    endsequence
    a_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 16'h0) else $error("read data outside read slot");
    a_reset_quiet: assert property (
        $fell(i_rst) |-> !o_eoc && !o_irq && o_mod_rst) else $error("outputs not idle");
    a_eoc_holds: assert property (
        o_eoc && !i_wr && !i_dma_ack && !(i_rd && i_addr == `DSADC_OFF_RESULT) |=> o_eoc)
        else $error("done dropped without read");
    a_ack_clears: assert property (
        o_eoc && o_mod_rst && i_dma_ack |=> !o_eoc) else $error("done kept after ack");
    a_eoc_from_run: assert property (
        $rose(o_eoc) |-> !$past(o_mod_rst)) else $error("done rose while idle");
    a_mux_primes: assert property (
        s_mux_hold |-> (!$rose(o_eoc)) [*3]) else $error("result during mux change");
    a_stat_done: assert property (
        s_stat_read |=> o_rdata[0] == $past(o_eoc)) else $error("status done differs");
    a_unmapped_zero: assert property (
        i_rd && i_addr > 4'h5 |=> o_rdata == 16'h0) else $error("unmapped read not zero");
endmodule
bind dsadc_seq dsadc_seq_props i_props (.i_clk, .i_rst, .i_addr, .i_wr, .i_rd, .o_rdata,
    .i_mux_change, .i_dma_ack, .o_mod_rst, .o_eoc, .o_irq);

// file: test/dsadc_dma_model.sv
// dma reader model: takes each flagged result after a set delay
module dsadc_dma_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_en,
    input  wire logic [3:0] i_delay,
    input  wire logic       i_eoc,
    output logic            o_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_ff;
    // reads only while a result is flagged, one pulse per result
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_en || o_ack || !i_eoc) begin
            o_ack   <= 1'b0;
            wait_ff <= 4'h0;
        end else if (wait_ff == i_delay) begin
            o_ack <= 1'b1;
        end else begin
            wait_ff <= wait_ff + 4'h1;
        end
    end
endmodule

// file: test/dsadc_seq_tb.sv
// self-checking bench for the converter sequencer
`include "dsadc_map.svh"
module dsadc_seq_tb;
    import dsadc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_mod_bit = 0, i_soc = 0;
    logic        i_mux_change = 0, i_dma_ack, o_mod_rst, o_eoc, o_irq, dma_en = 0, seen;
    logic [3:0]  i_addr = 4'h0, dly = 4'h0;
    logic [15:0] i_wdata = 16'h0, o_rdata, d;
    int          n_errors = 0, total_checks = 0, n, t;
    always #25 i_clk = ~i_clk;
    dsadc_seq i_dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_mod_bit,
        .i_soc, .i_mux_change, .i_dma_ack, .o_mod_rst, .o_eoc, .o_irq);
    dsadc_dma_model i_dma (.i_clk, .i_rst, .i_en(dma_en), .i_delay(dly), .i_eoc(o_eoc),
        .o_ack(i_dma_ack));
    task automatic chk(input string s, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= v;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // bounded so a stuck flag ends as a mismatch, not a hang
    task automatic wait_eoc(input logic lvl);
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_eoc !== lvl && n < 200);
        if (n >= 200) chk("eoc wait", 16'(lvl), 16'(o_eoc));
    endtask
    // decimation count 3 gives one sample every 4 clocks
    task automatic go(input dsadc_mode_t m);
        wr(`DSADC_OFF_CFG, {8'h03, 6'h00, m});
        wr(`DSADC_OFF_CTRL, 16'h0001);
    endtask
    task automatic halt;
        wr(`DSADC_OFF_CTRL, 16'h0002);
        wait_eoc(1'b0);
        @(posedge i_clk);
        dma_en <= 1'b0;
    endtask
    task automatic t_single;
        rd(`DSADC_OFF_CFG);
        chk("cfg reset", `DSADC_CFG_RST, d);
        rd(4'hf);
        chk("unmapped", 16'h0, d);
        go(DSADC_MODE_SINGLE);
        wait_eoc(1'b1);
        chk("four conversions", 16'h1, 16'(n >= 12 && n <= 30));
        rd(`DSADC_OFF_STAT);
        chk("stat done", 16'h1, {15'h0, d[0]});
        rd(`DSADC_OFF_IRQ_STAT);
        chk("irq stat", 16'h1, {15'h0, d[0]});
        chk("irq masked", 16'h0, {15'h0, o_irq});
        wr(`DSADC_OFF_IRQ_MASK, 16'h0001);
        repeat (2) @(negedge i_clk);
        chk("irq on", 16'h1, {15'h0, o_irq});
        wr(`DSADC_OFF_IRQ_STAT, 16'h0001);
        repeat (2) @(negedge i_clk);
        chk("irq cleared", 16'h0, {15'h0, o_irq});
        chk("eoc held", 16'h1, {15'h0, o_eoc});
        rd(`DSADC_OFF_RESULT);
        chk("zero input", 16'h0, d);
        repeat (40) @(negedge i_clk);
        chk("standby", 16'h0, {14'h0, o_eoc, ~o_mod_rst});
    endtask
    task automatic t_soc;
        @(posedge i_clk);
        i_mod_bit <= 1'b1;
        dma_en    <= 1'b1;
        i_soc     <= 1'b1;
        wait_eoc(1'b1);
        chk("soc start", 16'h1, 16'(n <= 30));
        wait_eoc(1'b0);
        chk("dma clears", 16'h1, 16'(n <= 4));
        @(posedge i_clk);
        i_soc  <= 1'b0;
        dma_en <= 1'b0;
    endtask
    task automatic t_multi(input dsadc_mode_t m);
        @(posedge i_clk);
        dma_en <= 1'b1;
        dly    <= 4'h5;
        go(m);
        wait_eoc(1'b1);
        seen = o_mod_rst;
        while (o_eoc === 1'b1) begin
            @(negedge i_clk);
            seen |= o_mod_rst;
        end
        wait_eoc(1'b1);
        chk("auto restart", 16'h1, 16'(n <= 30));
        chk("reset between", 16'h1, {15'h0, seen});
        halt;
    endtask
    task automatic t_cont;
        @(posedge i_clk);
        dma_en <= 1'b1;
        dly    <= 4'h0;
        go(DSADC_MODE_CONT);
        wait_eoc(1'b1);
        chk("cont priming", 16'h1, 16'(n >= 10 && n <= 30));
        wait_eoc(1'b0);
        t = n;
        wait_eoc(1'b1);
        chk("cont period", 16'd4, 16'(t + n));
        @(posedge i_clk);
        i_mux_change <= 1'b1;
        repeat (30) @(posedge i_clk);
        i_mux_change <= 1'b0;
        wait_eoc(1'b0);
        wait_eoc(1'b1);
        chk("prime after mux", 16'h1, 16'(n >= 12));
        halt;
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        t_single;
        t_soc;
        t_multi(DSADC_MODE_MULTI);
        t_multi(DSADC_MODE_TURBO);
        t_cont;
        test_done;
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        n_errors++;
        test_done;
    end
endmodule
